// *** core/pwmrt_cfg.svh ***
// Register map, field positions, reset values and event numbers of the PWM output stage
`ifndef PWMRT_CFG_SVH
`define PWMRT_CFG_SVH
`define PWMRT_ADDR_W        8
`define PWMRT_OFS_CLKCTRL   8'ha1
`define PWMRT_OFS_ROUTE     8'ha6
`define PWMRT_OFS_MODE      8'ha7
`define PWMRT_OFS_IE1       8'ha8
`define PWMRT_OFS_IE2       8'ha9
`define PWMRT_OFS_IRQ_STAT  8'hb0
`define PWMRT_OFS_IRQ_MASK  8'hb1
`define PWMRT_OFS_STATUS    8'hb2
`define PWMRT_RST_ROUTE     8'h00
`define PWMRT_RST_MODE      8'h00
`define PWMRT_RST_INTEN     8'h00
`define PWMRT_RST_CLKCTRL   8'h00
`define PWMRT_BIT_B_P1_2    7
`define PWMRT_BIT_B_P0_6    6
`define PWMRT_BIT_B_P0_4    5
`define PWMRT_BIT_B_P0_2    4
`define PWMRT_BIT_AN_P3_6   3
`define PWMRT_BIT_AP_P3_5   2
`define PWMRT_BIT_AN_P0_4   1
`define PWMRT_BIT_AP_P0_3   0
`define PWMRT_BIT_HALF      7
`define PWMRT_BIT_MSKE      6
`define PWMRT_OM_HI         5
`define PWMRT_OM_LO         4
`define PWMRT_DZ_HI         3
`define PWMRT_DZ_LO         0
`define PWMRT_BIT_GIE       7
`define PWMRT_BIT_PULSE_IRQ 7
`define PWMRT_CKS_HI        3
`define PWMRT_CKS_LO        2
`define PWMRT_BIT_NMSK      1
`define PWMRT_BIT_PMSK      0
`define PWMRT_NUM_EV        3
`define PWMRT_EV_PWM_IRQ    0
`define PWMRT_EV_DZ_DONE    1
`define PWMRT_EV_CFG_ERR    2
`endif

// *** core/pwmrt_pkg.sv ***
// Types shared by the PWM output stage
package pwmrt_pkg;
   typedef enum logic [1:0] {
      PWMRT_CKS_SYS0 = 2'h0,
      PWMRT_CKS_SYS1 = 2'h1,
      PWMRT_CKS_RC   = 2'h2,
      PWMRT_CKS_RC2  = 2'h3
   } pwmrt_cks_t;
   typedef enum logic [2:0] {
      PWMRT_DZ_IDLE = 3'b001,
      PWMRT_DZ_WAIT = 3'b010,
      PWMRT_DZ_DRV  = 3'b100
   } pwmrt_dz_state_t;
   typedef logic [7:0] pwmrt_byte_t;
endpackage : pwmrt_pkg

// *** core/pwmrt_sync.sv ***
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none
module pwmrt_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : pwmrt_sync
`default_nettype wire

// *** core/pwmrt_deadzone.sv ***
// Complementary leg generator with dead time counted in PWM clock ticks
`timescale 1ns/1ps
`default_nettype none
module pwmrt_deadzone
   import pwmrt_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Control
   input  wire logic       tick,
   input  wire logic [3:0] dead_time,
   input  wire logic       wave,
   // Legs
   output logic            pos_leg,
   output logic            neg_leg,
   output logic            dz_done
);
   pwmrt_dz_state_t state_reg;
   logic [3:0]      cnt_reg;
   logic            tgt_reg;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= PWMRT_DZ_DRV;
         cnt_reg   <= 4'h0;
         tgt_reg   <= 1'b0;
         pos_leg   <= 1'b0;
         neg_leg   <= 1'b1;
         dz_done   <= 1'b0;
      end else begin
         dz_done <= 1'b0;
         unique case (state_reg)
            PWMRT_DZ_DRV: begin
               if (wave != tgt_reg) begin
                  tgt_reg <= wave;
                  if (dead_time == 4'h0) begin
                     pos_leg <= wave;
                     neg_leg <= ~wave;
                  end else begin
                     // Both legs off before the new one turns on
                     pos_leg   <= 1'b0;
                     neg_leg   <= 1'b0;
                     cnt_reg   <= dead_time;
                     state_reg <= PWMRT_DZ_WAIT;
                  end
               end
            end
            PWMRT_DZ_WAIT: begin
               if (tick) begin
                  cnt_reg <= cnt_reg - 4'h1;
                  if (cnt_reg == 4'h1) begin
                     // Legs turn on at the last tick, so the gap is the count itself
                     // Latest waveform level wins, so a short glitch is not stretched
                     tgt_reg   <= wave;
                     pos_leg   <= wave;
                     neg_leg   <= ~wave;
                     state_reg <= PWMRT_DZ_IDLE;
                  end
               end
            end
            PWMRT_DZ_IDLE: begin
               // A wave change seen here is taken up one cycle later in the drive state
               dz_done   <= 1'b1;
               state_reg <= PWMRT_DZ_DRV;
            end
         endcase
      end
   end
endmodule : pwmrt_deadzone
`default_nettype wire

// *** core/pwmrt_top.sv ***
// PWM output stage: pin routing, mask, dead zone and interrupt gating
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pwmrt_cfg.svh"
module pwmrt_top
   import pwmrt_pkg::*;
(
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst,
   // Register port
   input  wire logic [`PWMRT_ADDR_W-1:0]  addr,
   input  wire logic [7:0]                wdata,
   input  wire logic                      wr,
   input  wire logic                      rd,
   output pwmrt_pkg::pwmrt_byte_t         rdata,
   // PWM core side, from the counter logic on this clock
   input  wire logic                      chan_a_wave,
   input  wire logic                      chan_b_wave,
   input  wire logic                      chan_a_clear_ctrl,
   input  wire logic                      pwm_irq_req,
   // Clock tick sources, from other domains
   input  wire logic                      internal_rc_osc,
   input  wire logic                      internal_rc_osc_x2,
   // Ordinary port data for each routable pin
   input  wire logic                      port_p1_2,
   input  wire logic                      port_p0_6,
   input  wire logic                      port_p0_4,
   input  wire logic                      port_p0_2,
   input  wire logic                      port_p3_6,
   input  wire logic                      port_p3_5,
   input  wire logic                      port_p0_3,
   // Pins
   output logic                           pin_p1_2,
   output logic                           pin_p0_6,
   output logic                           pin_p0_4,
   output logic                           pin_p0_2,
   output logic                           pin_p3_6,
   output logic                           pin_p3_5,
   output logic                           pin_p0_3,
   // Interrupt and mode state
   output logic                           irq,
   output logic [1:0]                     chan_a_output_mode,
   output logic                           chan_a_half_bridge_sel
);
   pwmrt_byte_t route_enable_reg;
   pwmrt_byte_t mode_deadtime_reg;
   pwmrt_byte_t intr_en_primary_reg;
   pwmrt_byte_t secondary_irq_enable_reg;
   pwmrt_byte_t clk_ctrl_reg;
   logic [`PWMRT_NUM_EV-1:0] irq_stat_reg;
   logic [`PWMRT_NUM_EV-1:0] irq_mask_reg;
   logic [`PWMRT_NUM_EV-1:0] ev_set;
   logic [1:0]  rc_sync;
   logic [1:0]  rc_last_reg;
   logic        tick;
   logic        pos_leg;
   logic        neg_leg;
   logic        dz_done;
   logic        chan_a_pos_out;
   logic        chan_a_neg_out;
   logic        pwm_irq_gated;
   logic [3:0]  chan_a_dead_time;
   pwmrt_cks_t  chan_a_clock_select;

   // Register writes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         route_enable_reg         <= `PWMRT_RST_ROUTE;
         mode_deadtime_reg        <= `PWMRT_RST_MODE;
         intr_en_primary_reg      <= `PWMRT_RST_INTEN;
         secondary_irq_enable_reg <= `PWMRT_RST_INTEN;
         clk_ctrl_reg             <= `PWMRT_RST_CLKCTRL;
         irq_mask_reg             <= '0;
      end else if (wr) begin
         unique case (addr)
            `PWMRT_OFS_ROUTE:    route_enable_reg         <= wdata;
            `PWMRT_OFS_MODE:     mode_deadtime_reg        <= wdata;
            `PWMRT_OFS_IE1:      intr_en_primary_reg      <= wdata;
            `PWMRT_OFS_IE2:      secondary_irq_enable_reg <= wdata;
            `PWMRT_OFS_CLKCTRL:  clk_ctrl_reg             <= wdata;
            `PWMRT_OFS_IRQ_MASK: irq_mask_reg <= wdata[`PWMRT_NUM_EV-1:0];
            default: ;
         endcase
      end
   end

   assign chan_a_dead_time    = mode_deadtime_reg[`PWMRT_DZ_HI:`PWMRT_DZ_LO];
   assign chan_a_clock_select = pwmrt_cks_t'(clk_ctrl_reg[`PWMRT_CKS_HI:`PWMRT_CKS_LO]);

   // Read data valid the cycle after the strobe; unmapped reads return zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            `PWMRT_OFS_ROUTE:    rdata <= route_enable_reg;
            `PWMRT_OFS_MODE:     rdata <= mode_deadtime_reg;
            `PWMRT_OFS_IE1:      rdata <= intr_en_primary_reg;
            `PWMRT_OFS_IE2:      rdata <= secondary_irq_enable_reg;
            `PWMRT_OFS_CLKCTRL:  rdata <= clk_ctrl_reg;
            `PWMRT_OFS_IRQ_STAT: rdata <= {5'h00, irq_stat_reg};
            `PWMRT_OFS_IRQ_MASK: rdata <= {5'h00, irq_mask_reg};
            `PWMRT_OFS_STATUS:   rdata <= {6'h00, neg_leg, pos_leg};
            default:             rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // RC oscillator levels are asynchronous, so they are synchronised first
   pwmrt_sync #(.W(2)) u_rc_sync (
      .clock (clock),
      .rst   (rst),
      .d     ({internal_rc_osc_x2, internal_rc_osc}),
      .q     (rc_sync)
   );

   always_ff @(posedge clock or posedge rst) begin
      if (rst) rc_last_reg <= 2'h0;
      else     rc_last_reg <= rc_sync;
   end

   // PWM clock tick; RC sources are edge-detected after synchronisation.
   // An RC source faster than half this clock loses ticks.
   always_comb begin
      unique case (chan_a_clock_select)
         PWMRT_CKS_RC:  tick = rc_sync[0] & ~rc_last_reg[0];
         PWMRT_CKS_RC2: tick = rc_sync[1] & ~rc_last_reg[1];
         default:       tick = 1'b1;
      endcase
   end

   pwmrt_deadzone u_deadzone (
      .clock     (clock),
      .rst       (rst),
      .tick      (tick),
      .dead_time (chan_a_dead_time),
      .wave      (chan_a_wave),
      .pos_leg   (pos_leg),
      .neg_leg   (neg_leg),
      .dz_done   (dz_done)
   );

   // Mask override while the clear control is asserted
   always_comb begin
      if (mode_deadtime_reg[`PWMRT_BIT_MSKE] && chan_a_clear_ctrl) begin
         chan_a_pos_out = clk_ctrl_reg[`PWMRT_BIT_PMSK];
         chan_a_neg_out = clk_ctrl_reg[`PWMRT_BIT_NMSK];
      end else begin
         chan_a_pos_out = pos_leg;
         chan_a_neg_out = neg_leg;
      end
   end

   // Pin multiplexers; P0.4 is shared by channel B and the negative leg,
   // channel B taking priority when both routes are on
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_p1_2 <= 1'b0;
         pin_p0_6 <= 1'b0;
         pin_p0_4 <= 1'b0;
         pin_p0_2 <= 1'b0;
         pin_p3_6 <= 1'b0;
         pin_p3_5 <= 1'b0;
         pin_p0_3 <= 1'b0;
      end else begin
         pin_p1_2 <= route_enable_reg[`PWMRT_BIT_B_P1_2] ? chan_b_wave : port_p1_2;
         pin_p0_6 <= route_enable_reg[`PWMRT_BIT_B_P0_6] ? chan_b_wave : port_p0_6;
         pin_p0_2 <= route_enable_reg[`PWMRT_BIT_B_P0_2] ? chan_b_wave : port_p0_2;
         if (route_enable_reg[`PWMRT_BIT_B_P0_4])
            pin_p0_4 <= chan_b_wave;
         else if (route_enable_reg[`PWMRT_BIT_AN_P0_4])
            pin_p0_4 <= chan_a_neg_out;
         else
            pin_p0_4 <= port_p0_4;
         pin_p3_6 <= route_enable_reg[`PWMRT_BIT_AN_P3_6] ? chan_a_neg_out : port_p3_6;
         pin_p3_5 <= route_enable_reg[`PWMRT_BIT_AP_P3_5] ? chan_a_pos_out : port_p3_5;
         pin_p0_3 <= route_enable_reg[`PWMRT_BIT_AP_P0_3] ? chan_a_pos_out : port_p0_3;
      end
   end

   // Interrupt gating
   assign pwm_irq_gated = pwm_irq_req & intr_en_primary_reg[`PWMRT_BIT_GIE]
                        & secondary_irq_enable_reg[`PWMRT_BIT_PULSE_IRQ];

   always_comb begin
      ev_set = '0;
      ev_set[`PWMRT_EV_PWM_IRQ] = pwm_irq_gated;
      ev_set[`PWMRT_EV_DZ_DONE] = dz_done;
      // Flags a dead time left set in half-bridge mode
      ev_set[`PWMRT_EV_CFG_ERR] = mode_deadtime_reg[`PWMRT_BIT_HALF] && (chan_a_dead_time != 4'h0);
   end

   // Sticky status, write one to clear, a new event wins over the clear
   genvar gi;
   generate
      for (gi = 0; gi < `PWMRT_NUM_EV; gi = gi + 1) begin : g_stat
         always_ff @(posedge clock or posedge rst) begin
            if (rst)
               irq_stat_reg[gi] <= 1'b0;
            else if (ev_set[gi])
               irq_stat_reg[gi] <= 1'b1;
            else if (wr && addr == `PWMRT_OFS_IRQ_STAT && wdata[gi])
               irq_stat_reg[gi] <= 1'b0;
         end
      end
   endgenerate

   // Global enable also blocks the summary output
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq                    <= 1'b0;
         chan_a_output_mode     <= 2'h0;
         chan_a_half_bridge_sel <= 1'b0;
      end else begin
         irq <= intr_en_primary_reg[`PWMRT_BIT_GIE] && |(irq_stat_reg & irq_mask_reg);
         chan_a_output_mode     <= mode_deadtime_reg[`PWMRT_OM_HI:`PWMRT_OM_LO];
         chan_a_half_bridge_sel <= mode_deadtime_reg[`PWMRT_BIT_HALF];
      end
   end
endmodule : pwmrt_top
`default_nettype wire

// *** test/pwmrt_top_chk_sva.sv ***
// Port checker for the PWM output stage
`timescale 1ns/1ps
`default_nettype none
module pwmrt_top_chk
   import pwmrt_pkg::*;
(
   // Clock, reset and register port
   input wire logic                   clock,
   input wire logic                   rst,
   input wire logic [7:0]             addr,
   input wire logic [7:0]             wdata,
   input wire logic                   wr,
   input wire logic                   rd,
   input wire pwmrt_pkg::pwmrt_byte_t rdata,
   // Core side and port data
   input wire logic                   chan_b_wave,
   input wire logic                   chan_a_clear_ctrl,
   input wire logic                   pwm_irq_req,
   input wire logic                   port_p1_2,
   input wire logic                   port_p0_2,
   // Outputs
   input wire logic                   pin_p1_2,
   input wire logic                   pin_p0_4,
   input wire logic                   pin_p0_2,
   input wire logic                   pin_p3_6,
   input wire logic                   pin_p3_5,
   input wire logic                   irq,
   input wire logic [1:0]             chan_a_output_mode,
   input wire logic                   chan_a_half_bridge_sel
);
   logic [7:0] route_reg, mode_reg, ie1_reg, ie2_reg, clk_reg, mask_reg, rd_exp;
   logic [1:0] quiet_reg;
   logic       rd_chk, gie, exp_p1_2, exp_p0_2, b_p0_4, msk_p, msk_n;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Shadow of the writable registers, updated on the same edge as the design
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         {route_reg, mode_reg, ie1_reg, ie2_reg, clk_reg, mask_reg} <= '0;
      end else if (wr) begin
         case (addr)
            8'ha6: route_reg <= wdata;
            8'ha7: mode_reg <= wdata;
            8'ha8: ie1_reg <= wdata;
            8'ha9: ie2_reg <= wdata;
            8'ha1: clk_reg <= wdata;
            8'hb1: mask_reg <= wdata;
            default: ;
         endcase
      end
   end
   // Exported copies may lag a write, so they are compared only once writes pause
   always_ff @(posedge clock or posedge rst) begin
      if (rst || wr)
         quiet_reg <= 2'h0;
      else if (quiet_reg != 2'h2)
         quiet_reg <= quiet_reg + 2'h1;
   end
   assign rd_chk = rd && (addr == 8'ha6 || addr == 8'ha7);
   assign rd_exp = (addr == 8'ha6) ? route_reg : mode_reg;
   assign gie = ie1_reg[7];
   assign exp_p1_2 = route_reg[7] ? chan_b_wave : port_p1_2;
   assign exp_p0_2 = route_reg[4] ? chan_b_wave : port_p0_2;
   assign b_p0_4 = route_reg[5];
   assign msk_p = mode_reg[6] && chan_a_clear_ctrl && route_reg[2];
   assign msk_n = mode_reg[6] && chan_a_clear_ctrl && route_reg[3];
   sequence s_gated_req;
      pwm_irq_req && gie && ie2_reg[7] && mask_reg[0];
   endsequence
   AST_CHB_P1_2: assert property (!$past(rst) |-> pin_p1_2 == $past(exp_p1_2))
      else $error("pin p1_2 route mismatch");
   AST_CHB_P0_2: assert property (!$past(rst) |-> pin_p0_2 == $past(exp_p0_2))
      else $error("pin p0_2 route mismatch");
   AST_CHB_P0_4: assert property ($past(b_p0_4) |-> pin_p0_4 == $past(chan_b_wave))
      else $error("pin p0_4 channel b mismatch");
   AST_MASK_POS: assert property ($past(msk_p) |-> pin_p3_5 == $past(clk_reg[0]))
      else $error("positive mask value missing");
   AST_MASK_NEG: assert property ($past(msk_n) |-> pin_p3_6 == $past(clk_reg[1]))
      else $error("negative mask value missing");
   AST_IRQ_OFF: assert property (!$past(gie) |-> !irq)
      else $error("irq with global enable off");
   AST_IRQ_PWM: assert property (s_gated_req [*2] |=> irq)
      else $error("irq missing after gated request");
   AST_MODE_COPY: assert property (quiet_reg == 2'h2 |->
      chan_a_output_mode == mode_reg[5:4] && chan_a_half_bridge_sel == mode_reg[7])
      else $error("mode outputs differ from register");
   AST_READBACK: assert property ($past(rd_chk) |-> rdata == $past(rd_exp))
      else $error("register readback mismatch");
endmodule : pwmrt_top_chk
bind pwmrt_top pwmrt_top_chk u_chk (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .chan_b_wave(chan_b_wave),
   .chan_a_clear_ctrl(chan_a_clear_ctrl), .pwm_irq_req(pwm_irq_req), .port_p1_2(port_p1_2),
   .port_p0_2(port_p0_2), .pin_p1_2(pin_p1_2), .pin_p0_4(pin_p0_4), .pin_p0_2(pin_p0_2),
   .pin_p3_6(pin_p3_6), .pin_p3_5(pin_p3_5), .irq(irq),
   .chan_a_output_mode(chan_a_output_mode), .chan_a_half_bridge_sel(chan_a_half_bridge_sel));
`default_nettype wire

// *** test/pwmrt_stage_model.sv ***
// Power stage model watching the two channel A leg pins
`timescale 1ns/1ps
`default_nettype none
module pwmrt_stage_model (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Gate drive pins
   input  wire logic       high_in,
   input  wire logic       low_in,
   // Observations
   output logic            overlap,
   output logic [4:0]      gap
);
   logic [4:0] cnt_reg;
   logic       hi_reg, lo_reg;
   // Both switches on shorts the supply, so it is latched for the bench
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         overlap <= 1'b0;
      else if (high_in && low_in)
         overlap <= 1'b1;
   end
   // Length of the last both-off interval, caught when either switch turns on
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         {cnt_reg, gap, hi_reg, lo_reg} <= '0;
      end else begin
         hi_reg <= high_in;
         lo_reg <= low_in;
         if ((high_in && !hi_reg) || (low_in && !lo_reg)) begin
            gap <= cnt_reg;
            cnt_reg <= 5'h00;
         end else if (!high_in && !low_in && cnt_reg != 5'h1f)
            cnt_reg <= cnt_reg + 5'h01;
      end
   end
endmodule : pwmrt_stage_model
`default_nettype wire

// *** test/pwmrt_top_tb.sv ***
// Self-checking bench for the PWM output stage
`timescale 1ns/1ps
`default_nettype none
module pwmrt_top_tb;
   import pwmrt_pkg::*;
   logic        clock = 0, rst = 1, wr = 0, rd = 0, wa = 0, clr = 0, req = 0, rc = 0, rc2 = 0;
   logic [7:0]  addr = 0, wdata = 0;
   logic [6:0]  port_v = 0;
   logic [1:0]  mode_out;
   logic        half, irq, overlap;
   logic [4:0]  gap;
   wire  [6:0]  pin_v;
   pwmrt_byte_t rdata;
   int          errors = 0, checks = 0;
   logic [7:0]  routes [11] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01,
                                8'h22, 8'hff, 8'h00};
   logic [3:0]  dzs [4] = '{4'h0, 4'h1, 4'h5, 4'hf};
   logic [7:0]  rst_regs [5] = '{8'ha6, 8'ha7, 8'ha8, 8'ha9, 8'ha1};
   always #50 clock = ~clock;
   always #350 rc <= ~rc;
   always #175 rc2 <= ~rc2;
   pwmrt_top dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .chan_a_wave(wa), .chan_b_wave(wa), .chan_a_clear_ctrl(clr),
      .pwm_irq_req(req), .internal_rc_osc(rc), .internal_rc_osc_x2(rc2),
      .port_p1_2(port_v[6]), .port_p0_6(port_v[5]), .port_p0_4(port_v[4]),
      .port_p0_2(port_v[3]), .port_p3_6(port_v[2]), .port_p3_5(port_v[1]),
      .port_p0_3(port_v[0]), .pin_p1_2(pin_v[6]), .pin_p0_6(pin_v[5]), .pin_p0_4(pin_v[4]),
      .pin_p0_2(pin_v[3]), .pin_p3_6(pin_v[2]), .pin_p3_5(pin_v[1]), .pin_p0_3(pin_v[0]),
      .irq(irq), .chan_a_output_mode(mode_out), .chan_a_half_bridge_sel(half));
   pwmrt_stage_model stage (.clock(clock), .rst(rst), .high_in(pin_v[1]), .low_in(pin_v[2]),
      .overlap(overlap), .gap(gap));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wreg
   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk(what, rdata, exp);
   endtask : rchk
   task automatic pulse;
      req <= 1'b1;
      cyc(2);
      req <= 1'b0;
      cyc(3);
   endtask : pulse
   // Channel B copies wa, so one level exercises both channels against the port data
   function automatic logic [7:0] exp_pins(input logic [7:0] r, input logic a, input logic p);
      exp_pins = {1'b0, r[7] ? a : p, r[6] ? a : p, r[5] ? a : (r[1] ? !a : p), r[4] ? a : p,
                  r[3] ? !a : p, r[2] ? a : p, r[0] ? a : p};
   endfunction : exp_pins
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   initial begin
      cyc(6);
      rst <= 1'b0;
      foreach (rst_regs[i]) rchk("reset value", rst_regs[i], 8'h00);
      wreg(8'h00, 8'h5a);
      rchk("unmapped", 8'h00, 8'h00);
      $display("test reset done");
      foreach (routes[i]) for (int k = 0; k < 4; k++) begin
         wreg(8'ha6, routes[i]);
         wa <= k[0];
         port_v <= {7{k[1]}};
         cyc(4);
         #1 chk("pins", {1'b0, pin_v}, exp_pins(routes[i], k[0], k[1]));
      end
      $display("test routing done");
      // Mid-run reset also clears the overlap latched while port data drove both legs high
      wreg(8'ha9, 8'h80);
      port_v <= 7'h00;
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      rchk("reset value", 8'ha9, 8'h00);
      wreg(8'ha6, 8'h0c);
      foreach (dzs[i]) begin
         wreg(8'ha7, {4'h0, dzs[i]});
         wa <= !wa;
         cyc(24);
         #1 chk("dead gap", {3'h0, gap}, {4'h0, dzs[i]});
      end
      chk("overlap", {7'h0, overlap}, 8'h00);
      // RC ticks come every 7 clocks, the doubled ones every 3 or 4; phase sets the bounds
      wreg(8'ha1, 8'h08);
      wreg(8'ha7, 8'h02);
      wa <= !wa;
      cyc(24);
      #1 chk("rc dead gap", {7'h0, gap >= 5'h08 && gap <= 5'h0e}, 8'h01);
      wreg(8'ha1, 8'h0c);
      wreg(8'ha7, 8'h04);
      wa <= !wa;
      cyc(24);
      #1 chk("rc2 dead gap", {7'h0, gap >= 5'h0b && gap <= 5'h0f}, 8'h01);
      $display("test dead time done");
      wreg(8'ha7, 8'h40);
      wreg(8'ha1, 8'h02);
      clr <= 1'b1;
      cyc(3);
      #1 chk("mask legs", {6'h0, pin_v[2:1]}, 8'h02);
      wreg(8'ha1, 8'h00);
      cyc(2);
      #1 chk("mask legs", {6'h0, pin_v[2:1]}, 8'h00);
      wreg(8'ha7, 8'h00);
      cyc(3);
      #1 chk("unmasked legs", {6'h0, pin_v[2:1]}, {6'h0, !wa, wa});
      $display("test mask done");
      for (int m = 0; m < 4; m++) begin
         wreg(8'ha7, {2'h0, m[1:0], 4'h0});
         cyc(2);
         #1 chk("output mode", {6'h0, mode_out}, {6'h0, m[1:0]});
      end
      wreg(8'ha7, 8'h80); // half-bridge with the dead time field written as zero
      rchk("mode register", 8'ha7, 8'h80);
      chk("half bridge", {7'h0, half}, 8'h01);
      $display("test mode done");
      wreg(8'hb1, 8'h01);
      wreg(8'ha9, 8'h80);
      pulse();
      #1 chk("irq global off", {7'h0, irq}, 8'h00);
      wreg(8'ha8, 8'h80);
      wreg(8'ha9, 8'h00);
      pulse();
      #1 chk("irq source off", {7'h0, irq}, 8'h00);
      wreg(8'ha9, 8'h80);
      pulse();
      #1 chk("irq raised", {7'h0, irq}, 8'h01);
      wreg(8'ha8, 8'h00);
      cyc(2);
      #1 chk("irq gated", {7'h0, irq}, 8'h00);
      wreg(8'hb0, 8'h01);
      rchk("status", 8'hb0, 8'h02);
      wreg(8'ha8, 8'h80);
      cyc(2);
      #1 chk("irq cleared", {7'h0, irq}, 8'h00);
      $display("test interrupt done");
      report_and_stop();
   end
endmodule : pwmrt_top_tb
`default_nettype wire
